//--- mit_pkg.sv
/*
  Shared constants and types of the motion and inactivity timing block:
  register offsets, field positions, reset values, timer scales and the
  packed sample carrier. Assumes a 50 MHz system clock.
*/
// How it works
// - Activity is flagged only after above-threshold motion lasts the programmed code count.
// - Activity code lasts 3.3 ms at 6400 Hz rate, 6.6 ms at lower rates.
// - Inactivity compares each signed 12-bit sample magnitude with an unsigned 11-bit limit.
// - Limit bits 10..3 come from high register, bits 2..0 from low bits 7..5.
// - X low register bit 1 picks referenced (1) or absolute (0) inactivity processing.
// - Low register bit 0 lets that axis take part in inactivity detection.
// - Inactivity reported only when all enabled axes stay below limits for the duration.
// - Inactivity duration is low byte plus high byte forming sixteen bits.
// - Inactivity code lasts 26 ms at 3200 Hz or lower, 13 ms at 6400 Hz.
// - Activity compares enabled axis magnitudes with unsigned 11-bit activity limits, exceeding counts.
package mit_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] ADDR_ACTIVITY_DURATION = 8'h29;
  localparam logic [7:0] ADDR_STILL_X_HIGH = 8'h2a;
  localparam logic [7:0] ADDR_STILL_X_LOW = 8'h2b;
  localparam logic [7:0] ADDR_STILL_Y_HIGH = 8'h2c;
  localparam logic [7:0] ADDR_STILL_Y_LOW = 8'h2d;
  localparam logic [7:0] ADDR_STILL_Z_HIGH = 8'h2e;
  localparam logic [7:0] ADDR_STILL_Z_LOW = 8'h2f;
  localparam logic [7:0] ADDR_STILL_DUR_HIGH = 8'h30;
  localparam logic [7:0] ADDR_STILL_DUR_LOW = 8'h31;
  localparam logic [7:0] ADDR_FIRST = ADDR_ACTIVITY_DURATION;
  localparam logic [7:0] ADDR_LAST = ADDR_STILL_DUR_LOW;
  localparam int unsigned REG_COUNT = 9;

  // Storage index of each register (offset minus first offset)
  localparam logic [3:0] IDX_ACT_DUR = 4'h0;
  localparam logic [3:0] IDX_X_HIGH = 4'h1;
  localparam logic [3:0] IDX_X_LOW = 4'h2;
  localparam logic [3:0] IDX_Y_HIGH = 4'h3;
  localparam logic [3:0] IDX_Y_LOW = 4'h4;
  localparam logic [3:0] IDX_Z_HIGH = 4'h5;
  localparam logic [3:0] IDX_Z_LOW = 4'h6;
  localparam logic [3:0] IDX_DUR_HIGH = 4'h7;
  localparam logic [3:0] IDX_DUR_LOW = 4'h8;

  // Field layout of the low/control registers
  localparam int unsigned LOW_LIMIT_MSB = 7;
  localparam int unsigned LOW_LIMIT_LSB = 5;
  localparam int unsigned BIT_REFERENCED = 1;
  localparam int unsigned BIT_PARTICIPATE = 0;
  localparam logic [7:0] MASK_X_LOW = 8'he3;
  localparam logic [7:0] MASK_YZ_LOW = 8'he1;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Timer scales; cycle counts derive from time and clock rate
  localparam int unsigned CLK_KHZ = 50000;
  localparam int unsigned ACT_CODE_FAST_US = 3300;
  localparam int unsigned ACT_CODE_SLOW_US = 6600;
  localparam int unsigned STILL_CODE_FAST_US = 13000;
  localparam int unsigned STILL_CODE_SLOW_US = 26000;
  localparam int unsigned ACT_CODE_FAST_CYC = ACT_CODE_FAST_US * CLK_KHZ / 1000;
  localparam int unsigned ACT_CODE_SLOW_CYC = ACT_CODE_SLOW_US * CLK_KHZ / 1000;
  localparam int unsigned STILL_CODE_FAST_CYC = STILL_CODE_FAST_US * CLK_KHZ / 1000;
  localparam int unsigned STILL_CODE_SLOW_CYC = STILL_CODE_SLOW_US * CLK_KHZ / 1000;
  localparam int unsigned PRESCALE_W = 21;

  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned LIMIT_W = 11;

  // One acceleration sample, three signed axes
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] x;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] z;
  } mit_sample_type;

  // Three 11-bit limits
  typedef struct packed {
    logic [LIMIT_W-1:0] x;
    logic [LIMIT_W-1:0] y;
    logic [LIMIT_W-1:0] z;
  } mit_limits_type;

endpackage : mit_pkg

//--- mit_motion_timing.sv
/*
  Activity duration timing and per-axis inactivity detection with the
  byte registers that steer them. Assumes an outside serial deserialiser
  presents single-byte register reads and writes, and a sample source
  that strobes one three-axis sample at a time, all synchronous to clk_sys.
  The sample strobe may also stand as a level; every high cycle is then
  taken as one new sample. Durations count whole code periods, whose
  length in clock cycles is a parameter so a bench can shorten them.
  Activity limits and axis enables arrive as levels from a neighbouring
  block; interrupt routing and the motion-warning limits live elsewhere.
*/
`timescale 1ns/1ps
module mit_motion_timing #(
  parameter int unsigned ACT_FAST_CYC = mit_pkg::ACT_CODE_FAST_CYC,
  parameter int unsigned ACT_SLOW_CYC = mit_pkg::ACT_CODE_SLOW_CYC,
  parameter int unsigned STILL_FAST_CYC = mit_pkg::STILL_CODE_FAST_CYC,
  parameter int unsigned STILL_SLOW_CYC = mit_pkg::STILL_CODE_SLOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Byte register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Sample stream and rate
  input wire logic sample_valid,
  input wire mit_pkg::mit_sample_type sample,
  input wire logic output_rate_6400,
  // Activity limits and axis enables held elsewhere
  input wire mit_pkg::mit_limits_type activity_limits,
  input wire logic [2:0] activity_participate,
  // Events and levels
  output logic activity_event,
  output logic activity_detected,
  output logic still_event,
  output logic still_detected
);

  // Register storage and decoded fields
  logic [7:0] cfg_mem_r [0:mit_pkg::REG_COUNT-1];
  logic [3:0] wr_idx;
  logic wr_hit;
  logic [7:0] wr_mask;
  mit_pkg::mit_limits_type still_limits;
  logic still_referenced_select;
  logic still_x_participate;
  logic still_y_participate;
  logic still_z_participate;
  logic [7:0] activity_duration_codes;
  logic [15:0] still_duration_codes;
  // Run, prescaler and counter state
  mit_pkg::mit_sample_type ref_sample_r;
  logic act_cond;
  logic still_cond;
  logic [mit_pkg::PRESCALE_W-1:0] act_pre_r;
  logic [mit_pkg::PRESCALE_W-1:0] still_pre_r;
  logic [mit_pkg::PRESCALE_W-1:0] act_pre_end;
  logic [mit_pkg::PRESCALE_W-1:0] still_pre_end;
  logic act_tick;
  logic still_tick;
  logic act_run_r;
  logic still_run_r;
  logic [7:0] act_cnt_r;
  logic [15:0] still_cnt_r;
  logic act_reached;
  logic still_reached;

  // Offset to storage index; out-of-map offsets miss
  // The caller gates with addr_in_map, since the index alone would alias
  function automatic logic [3:0] addr_to_idx(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - mit_pkg::ADDR_FIRST;
    return diff[3:0];
  endfunction : addr_to_idx

  function automatic logic addr_in_map(input logic [7:0] addr);
    return (addr >= mit_pkg::ADDR_FIRST) && (addr <= mit_pkg::ADDR_LAST);
  endfunction : addr_in_map

  // Writable bits per register; reserved bits stay zero
  // Masking at write time keeps read-back free of extra logic
  function automatic logic [7:0] idx_mask(input logic [3:0] idx);
    case (idx)
      mit_pkg::IDX_X_LOW: return mit_pkg::MASK_X_LOW;
      mit_pkg::IDX_Y_LOW,
      mit_pkg::IDX_Z_LOW: return mit_pkg::MASK_YZ_LOW;
      default: return mit_pkg::MASK_FULL;
    endcase
  endfunction : idx_mask

  // Magnitude of a signed sample; -2048 maps to 2048 without wrapping
  // Twelve unsigned bits suffice because the result is never below zero
  function automatic logic [mit_pkg::SAMPLE_W-1:0] magnitude(
    input logic signed [mit_pkg::SAMPLE_W-1:0] v);
    return v[mit_pkg::SAMPLE_W-1] ? (~v + 1'b1) : v;
  endfunction : magnitude

  // Difference of two samples, saturated so referenced mode cannot wrap
  // The cost is one extra subtractor bit per axis
  function automatic logic [mit_pkg::SAMPLE_W-1:0] delta_mag(
    input logic signed [mit_pkg::SAMPLE_W-1:0] a,
    input logic signed [mit_pkg::SAMPLE_W-1:0] b);
    logic signed [mit_pkg::SAMPLE_W:0] d;
    logic [mit_pkg::SAMPLE_W:0] m;
    d = {a[mit_pkg::SAMPLE_W-1], a} - {b[mit_pkg::SAMPLE_W-1], b};
    m = d[mit_pkg::SAMPLE_W] ? (~d + 1'b1) : d;
    return m[mit_pkg::SAMPLE_W] ? {mit_pkg::SAMPLE_W{1'b1}} : m[mit_pkg::SAMPLE_W-1:0];
  endfunction : delta_mag

  // Eleven-bit limit from a high byte and the top bits of a low byte
  // Reserved and control bits of the low byte are dropped here
  function automatic logic [mit_pkg::LIMIT_W-1:0] join_limit(
    input logic [7:0] high, input logic [7:0] low);
    return {high, low[mit_pkg::LOW_LIMIT_MSB:mit_pkg::LOW_LIMIT_LSB]};
  endfunction : join_limit

  assign wr_idx = addr_to_idx(reg_addr);
  assign wr_hit = reg_wr && addr_in_map(reg_addr);
  assign wr_mask = idx_mask(wr_idx);

  // Register writes; unmapped offsets are ignored
  // A read in the same cycle as a write to that offset returns the old byte
  // Reset clears every byte, so inactivity detection starts disabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < mit_pkg::REG_COUNT; i++) begin
        cfg_mem_r[i] <= mit_pkg::RESET_BYTE;
      end
    end else if (wr_hit) begin
      cfg_mem_r[wr_idx] <= reg_wdata & wr_mask;
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  // The byte holds between reads so a slow deserialiser can pick it up late
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= mit_pkg::RESET_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= addr_in_map(reg_addr) ? cfg_mem_r[addr_to_idx(reg_addr)]
                                           : mit_pkg::RESET_BYTE;
      end
    end
  end

  // Field decode of the stored bytes
  // Pure wiring; no state beyond the byte store itself
  assign still_limits.x = join_limit(cfg_mem_r[mit_pkg::IDX_X_HIGH],
                                     cfg_mem_r[mit_pkg::IDX_X_LOW]);
  assign still_limits.y = join_limit(cfg_mem_r[mit_pkg::IDX_Y_HIGH],
                                     cfg_mem_r[mit_pkg::IDX_Y_LOW]);
  assign still_limits.z = join_limit(cfg_mem_r[mit_pkg::IDX_Z_HIGH],
                                     cfg_mem_r[mit_pkg::IDX_Z_LOW]);
  assign still_referenced_select =
    cfg_mem_r[mit_pkg::IDX_X_LOW][mit_pkg::BIT_REFERENCED];
  assign still_x_participate = cfg_mem_r[mit_pkg::IDX_X_LOW][mit_pkg::BIT_PARTICIPATE];
  assign still_y_participate = cfg_mem_r[mit_pkg::IDX_Y_LOW][mit_pkg::BIT_PARTICIPATE];
  assign still_z_participate = cfg_mem_r[mit_pkg::IDX_Z_LOW][mit_pkg::BIT_PARTICIPATE];
  assign activity_duration_codes = cfg_mem_r[mit_pkg::IDX_ACT_DUR];
  assign still_duration_codes = {cfg_mem_r[mit_pkg::IDX_DUR_HIGH],
                                 cfg_mem_r[mit_pkg::IDX_DUR_LOW]};

  // Activity: any enabled axis magnitude strictly above its limit
  // A sample equal to its limit does not count as motion
  // Absolute magnitude only; a referenced activity mode would live outside
  always_comb begin
    act_cond = (activity_participate[2] &&
                magnitude(sample.x) > {1'b0, activity_limits.x}) ||
               (activity_participate[1] &&
                magnitude(sample.y) > {1'b0, activity_limits.y}) ||
               (activity_participate[0] &&
                magnitude(sample.z) > {1'b0, activity_limits.z});
  end

  // Inactivity: every enabled axis below its limit, none enabled means never
  // Strictly below, so a limit of zero keeps its axis from ever passing
  // An enabled axis with no limit programmed therefore blocks the event
  always_comb begin
    logic [mit_pkg::SAMPLE_W-1:0] mx;
    logic [mit_pkg::SAMPLE_W-1:0] my;
    logic [mit_pkg::SAMPLE_W-1:0] mz;
    mx = magnitude(sample.x);
    my = magnitude(sample.y);
    mz = magnitude(sample.z);
    if (still_referenced_select && still_run_r) begin
      mx = delta_mag(sample.x, ref_sample_r.x);
      my = delta_mag(sample.y, ref_sample_r.y);
      mz = delta_mag(sample.z, ref_sample_r.z);
    end
    still_cond = (still_x_participate || still_y_participate || still_z_participate) &&
                 (!still_x_participate || mx < {1'b0, still_limits.x}) &&
                 (!still_y_participate || my < {1'b0, still_limits.y}) &&
                 (!still_z_participate || mz < {1'b0, still_limits.z});
  end

  // Reference for referenced mode: the sample that opens a quiet run
  // Captured on every sample while no run stands; the first sample of a run
  // is judged by absolute magnitude since no reference exists yet
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_sample_r <= '0;
    end else if (sample_valid && (!still_run_r || !still_cond)) begin
      ref_sample_r <= sample;
    end
  end

  // Code period follows the output rate
  // The tick compares with >=, so a change to a shorter period ends the
  // current code at once instead of letting the prescaler wrap
  assign act_pre_end = output_rate_6400 ? mit_pkg::PRESCALE_W'(ACT_FAST_CYC - 1)
                                        : mit_pkg::PRESCALE_W'(ACT_SLOW_CYC - 1);
  assign still_pre_end = output_rate_6400 ? mit_pkg::PRESCALE_W'(STILL_FAST_CYC - 1)
                                          : mit_pkg::PRESCALE_W'(STILL_SLOW_CYC - 1);
  assign act_tick = act_run_r && (act_pre_r >= act_pre_end);
  assign still_tick = still_run_r && (still_pre_r >= still_pre_end);

  // Activity run state: opened and broken only by new samples
  // Nothing is known between strobes, so the run only moves on a strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_run_r <= 1'b0;
    end else if (sample_valid) begin
      act_run_r <= act_cond;
    end
  end

  // Activity code prescaler and code counter; both restart on a break
  // The counter saturates so a very long run never wraps and fires twice
  // Counting starts on the edge after the opening sample is taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_pre_r <= '0;
      act_cnt_r <= '0;
    end else if (sample_valid && !act_cond) begin
      act_pre_r <= '0;
      act_cnt_r <= '0;
    end else if (act_run_r) begin
      act_pre_r <= act_tick ? '0 : act_pre_r + 1'b1;
      if (act_tick && act_cnt_r != '1) begin
        act_cnt_r <= act_cnt_r + 1'b1;
      end
    end
  end

  // A zero count fires on the first qualifying sample
  // Lowering the duration mid-run fires at once, as the test is >=
  assign act_reached = act_run_r && (act_cnt_r >= activity_duration_codes);

  // Activity event is a single pulse per sustained run
  // The level follows the run and drops two cycles after a breaking sample
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      activity_detected <= 1'b0;
      activity_event <= 1'b0;
    end else begin
      activity_event <= act_reached && !activity_detected;
      activity_detected <= act_reached;
    end
  end

  // Inactivity run state
  // Opened and broken only by new samples, as for activity
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      still_run_r <= 1'b0;
    end else if (sample_valid) begin
      still_run_r <= still_cond;
    end
  end

  // Inactivity code prescaler and sixteen-bit code counter
  // The counter saturates at its top so a long quiet spell never re-fires
  // Its own prescaler lets the two timers start and stop independently
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      still_pre_r <= '0;
      still_cnt_r <= '0;
    end else if (sample_valid && !still_cond) begin
      still_pre_r <= '0;
      still_cnt_r <= '0;
    end else if (still_run_r) begin
      still_pre_r <= still_tick ? '0 : still_pre_r + 1'b1;
      if (still_tick && still_cnt_r != '1) begin
        still_cnt_r <= still_cnt_r + 1'b1;
      end
    end
  end

  // The whole sixteen-bit duration, high and low bytes, gates the event
  assign still_reached = still_run_r && (still_cnt_r >= still_duration_codes);

  // Inactivity event pulse; the level holds until motion breaks the run
  // A single pulse per quiet run, however long it lasts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      still_detected <= 1'b0;
      still_event <= 1'b0;
    end else begin
      still_event <= still_reached && !still_detected;
      still_detected <= still_reached;
    end
  end

endmodule : mit_motion_timing

//--- mit_motion_timing_chk.sv
/*
  Port checker of the motion timing block: read answers and event pulses.
  Assumes a bind onto mit_motion_timing with one clock domain.
*/
`timescale 1ns/1ps
module mit_motion_timing_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sample_valid,
  input wire mit_pkg::mit_sample_type sample,
  input wire logic output_rate_6400,
  input wire mit_pkg::mit_limits_type activity_limits,
  input wire logic [2:0] activity_participate,
  input wire logic activity_event,
  input wire logic activity_detected,
  input wire logic still_event,
  input wire logic still_detected
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // A read is a strobe, then a registered answer
  sequence s_rd;
    reg_rd;
  endsequence
  sequence s_ans;
    reg_rvalid;
  endsequence
  // Events are pulses that fall back after one cycle
  sequence s_act_pulse;
    activity_event ##1 !activity_event;
  endsequence
  sequence s_still_pulse;
    still_event ##1 !still_event;
  endsequence
  a_read_answered: assert property (s_rd |=> s_ans)
    else $error("read strobe without answer");
  a_answer_caused: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read strobe");
  a_unmapped_zero: assert property ((reg_rd && (reg_addr < 8'h29 || reg_addr > 8'h31))
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_act_one_pulse: assert property (activity_event |-> s_act_pulse)
    else $error("activity event longer than a cycle");
  a_act_with_level: assert property (activity_event |-> activity_detected)
    else $error("activity event without level");
  a_act_rise_event: assert property ($rose(activity_detected) |-> activity_event)
    else $error("activity level rose without event");
  a_act_drop_cause: assert property ($fell(activity_detected) |-> $past(sample_valid, 2))
    else $error("activity level fell without sample");
  a_still_one_pulse: assert property (still_event |-> s_still_pulse)
    else $error("still event longer than a cycle");
  a_still_with_level: assert property (still_event |-> still_detected)
    else $error("still event without level");
  a_still_rise_event: assert property ($rose(still_detected) |-> still_event)
    else $error("still level rose without event");
  a_still_drop_cause: assert property ($fell(still_detected) |-> $past(sample_valid, 2))
    else $error("still level fell without sample");
endmodule : mit_motion_timing_chk

//--- mit_host.sv
/*
  Host model of the byte register port: single-byte writes and reads.
  Assumes the block answers a read one cycle after the strobe edge.
*/
`timescale 1ns/1ps
module mit_host (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Quiet port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines flip so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : mit_host

//--- tb_motion_inactivity_timing.sv
/*
  Self-checking bench of the motion timing block, random durations.
  Assumes the host model and the port checker beside it.
*/
`timescale 1ns/1ps
module tb_motion_inactivity_timing;
  // Short code periods keep every run brief
  localparam int AF = 4;
  localparam int AS = 8;
  localparam int SF = 16;
  localparam int SS = 32;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic sample_valid = 1'b0;
  logic output_rate_6400 = 1'b0;
  logic [2:0] activity_participate = 3'h0;
  logic activity_event, activity_detected, still_event, still_detected;
  mit_pkg::mit_sample_type sample = '0;
  mit_pkg::mit_limits_type activity_limits = {11'h00a, 11'h00a, 11'h00a};
  int err_count = 0;
  int checks = 0;
  int seed = 32'h22b85c84;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  mit_host i_mit_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  mit_motion_timing #(.ACT_FAST_CYC(AF), .ACT_SLOW_CYC(AS), .STILL_FAST_CYC(SF),
    .STILL_SLOW_CYC(SS)) i_mit_motion_timing (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
    .sample(sample), .output_rate_6400(output_rate_6400),
    .activity_limits(activity_limits), .activity_participate(activity_participate),
    .activity_event(activity_event), .activity_detected(activity_detected),
    .still_event(still_event), .still_detected(still_detected));
  // Hang guard; the tests need well under half of this
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic mit_pkg::mit_sample_type mk(input int x, input int y, input int z);
    mk = {x[11:0], y[11:0], z[11:0]};
  endfunction : mk
  // Count starts at the edge after the opening sample is taken; the event
  // pulse is seen one cycle after the coded time has run out
  function automatic int lat(input int n, input bit still, input bit fast);
    lat = n * (still ? (fast ? SF : SS) : (fast ? AF : AS)) + 1;
  endfunction : lat
  // Writable bits per offset; reserved and unmapped bits read zero
  function automatic logic [7:0] msk(input int a);
    if (a == 8'h2b) msk = 8'he3;
    else if (a == 8'h2d || a == 8'h2f) msk = 8'he1;
    else if (a >= 8'h29 && a <= 8'h31) msk = 8'hff;
    else msk = 8'h00;
  endfunction : msk
  // Opening sample, then a held sample; expn below zero means no event
  task automatic run(input mit_pkg::mit_sample_type a, input mit_pkg::mit_sample_type b,
      input mit_pkg::mit_sample_type clr, input bit still, input int expn, input int lim);
    int n;
    bit seen;
    n = 0;
    seen = 1'b0;
    @(posedge clk_sys);
    sample <= a;
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample <= b;
    while (!seen && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
      seen = still ? (still_event === 1'b1) : (activity_event === 1'b1);
    end
    chk("event latency", (expn < 0) ? 16'h0 : expn[15:0], seen ? n[15:0] : 16'h0);
    @(posedge clk_sys);
    sample <= clr;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : run
  initial begin
    logic [7:0] d;
    logic [7:0] w;
    logic v;
    int n;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values and masked write-back, unmapped neighbours included
    for (int a = 8'h28; a <= 8'h32; a++) begin
      i_mit_host.rd(a[7:0], d, v);
      chk("reset read", 16'h0100, {7'h00, v, d});
      w = $random(seed);
      i_mit_host.wr(a[7:0], w);
      i_mit_host.rd(a[7:0], d, v);
      chk("write back", {8'h01, w & msk(a)}, {7'h00, v, d});
    end
    // A second reset must clear the random contents
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    i_mit_host.rd(8'h2b, d, v);
    chk("second reset", 16'h0100, {7'h00, v, d});
    $display("test registers done");
    @(posedge clk_sys);
    activity_participate <= 3'b100;
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 0 : $unsigned($random(seed)) % 4;
      output_rate_6400 <= i[0];
      i_mit_host.wr(8'h29, n[7:0]);
      run(mk(-20,0,0), mk(11,0,0), mk(0,0,0), 1'b0, lat(n, 1'b0, i[0]), 60);
    end
    output_rate_6400 <= 1'b0;
    i_mit_host.wr(8'h29, 8'h02);
    run(mk(10,0,0), mk(-10,0,0), mk(0,0,0), 1'b0, -1, 40);
    run(mk(0,900,0), mk(0,-900,0), mk(0,0,0), 1'b0, -1, 40);
    run(mk(30,0,0), mk(30,0,0), mk(0,0,0), 1'b0, -1, 12);
    run(mk(30,0,0), mk(30,0,0), mk(0,0,0), 1'b0, lat(2, 1'b0, 1'b0), 40);
    // Only z takes part: z motion counts, x motion is ignored
    activity_participate <= 3'b001;
    run(mk(0,0,-30), mk(0,0,30), mk(0,0,0), 1'b0, lat(2, 1'b0, 1'b0), 40);
    run(mk(30,0,0), mk(-30,0,0), mk(0,0,0), 1'b0, -1, 40);
    $display("test activity done");
    // Limit x is ten: high byte 01, low bits 010
    activity_participate <= 3'b000;
    i_mit_host.wr(8'h2a, 8'h01);
    i_mit_host.wr(8'h2b, 8'h41);
    for (int i = 0; i < 4; i++) begin
      n = $unsigned($random(seed)) % 4;
      output_rate_6400 <= i[0];
      i_mit_host.wr(8'h31, n[7:0]);
      run(mk(-9,2000,-2000), mk(9,-2000,2000), mk(500,0,0), 1'b1, lat(n, 1'b1, i[0]),
        120);
    end
    output_rate_6400 <= 1'b1;
    i_mit_host.wr(8'h31, 8'h01);
    run(mk(-10,0,0), mk(10,0,0), mk(500,0,0), 1'b1, -1, 60);
    i_mit_host.wr(8'h2b, 8'he1);
    run(mk(14,0,0), mk(-14,0,0), mk(500,0,0), 1'b1, lat(1, 1'b1, 1'b1), 60);
    for (int r = 0; r < 2; r++) begin
      i_mit_host.wr(8'h2b, {6'h10, r[0], 1'b1});
      run(mk(3,0,0), mk(12,0,0), mk(500,0,0), 1'b1, r ? lat(1, 1'b1, 1'b1) : -1, 60);
    end
    i_mit_host.wr(8'h2b, 8'h41);
    i_mit_host.wr(8'h2d, 8'h01);
    run(mk(0,0,0), mk(0,0,0), mk(500,0,0), 1'b1, -1, 60);
    i_mit_host.wr(8'h2d, 8'h00);
    i_mit_host.wr(8'h2b, 8'h40);
    run(mk(0,0,0), mk(0,0,0), mk(500,0,0), 1'b1, -1, 60);
    // High byte alone: 256 codes at the fast rate
    i_mit_host.wr(8'h2b, 8'h41);
    i_mit_host.wr(8'h31, 8'h00);
    i_mit_host.wr(8'h30, 8'h01);
    run(mk(1,0,0), mk(-1,0,0), mk(500,0,0), 1'b1, lat(256, 1'b1, 1'b1), 4200);
    $display("test inactivity done");
    wrap_up();
  end
endmodule : tb_motion_inactivity_timing
bind mit_motion_timing mit_motion_timing_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
  .sample(sample), .output_rate_6400(output_rate_6400),
  .activity_limits(activity_limits), .activity_participate(activity_participate),
  .activity_event(activity_event), .activity_detected(activity_detected),
  .still_event(still_event), .still_detected(still_detected));
